// *** unbal_consts.svh ***
`ifndef UNBAL_CONSTS_SVH
`define UNBAL_CONSTS_SVH

// Register byte offsets
`define ADDR_W          6
`define REG_CTRL        6'h00
`define REG_THR_DEV     6'h04
`define REG_THR_OBJ     6'h08
`define REG_RATIO       6'h0C
`define REG_DELAY       6'h10
`define REG_K           6'h14
`define REG_TAU         6'h18
`define REG_IB          6'h1C
`define REG_STATUS      6'h20
`define REG_MASK        6'h24
`define REG_STATE       6'h28
`define REG_CMD         6'h2C

// Reset values
`define CTRL_RST        5'h00
`define THR_DEV_RST     16'h0400
`define THR_OBJ_RST     16'h0400
`define RATIO_RST       8'h00
`define DELAY_RST       16'h03E8
`define K_RST           16'h000A
`define TAU_RST         16'h0064
`define IB_RST          16'h1000

// Event bits in STATUS and MASK
`define EV_W            3
`define EV_PICKUP       0
`define EV_TRIP         1
`define EV_HOT          2
// STATE bits
`define ST_W            4
// CMD bit
`define CMD_PROT_RESET  0

// Fixed point: phase currents Q.12, one unit of nominal current = 4096
`define CUR_W           16
`define PU_FRAC         12
`define PU_ONE_SQ       64'h0000_0000_0100_0000
`define MAG_W           40
`define ROT_C           14'sh0DDB
`define SEQ_GAIN_SQ     9
`define PCT_FULL_SQ     10000
`define ZERO_FRAC_DIV   100

// Timing
`define CLK_HZ          100000000
`define EVAL_RATE_HZ    1000
`define DELAY_UNIT_US   1000
`define DELAY_UNIT_CYC  (`CLK_HZ / 1000000 * `DELAY_UNIT_US)
`define DIV_CYC_MIN     70
`define EVAL_RATE_MAX   4096

`endif

// *** unbal_pkg.sv ***
`include "unbal_consts.svh"
package unbal_pkg;

  typedef struct packed {
    logic signed [`CUR_W-1:0] re;
    logic signed [`CUR_W-1:0] im;
  } phasor_t;

  typedef struct packed {
    phasor_t ph_a;
    phasor_t ph_b;
    phasor_t ph_c;
  } abc_t;

  typedef struct packed {
    logic phase_rev;
    logic ratio_en;
    logic obj_base;
    logic inverse;
    logic enable;
  } ctrl_t;

  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_RUN  = 3'b010,
    DIV_DONE = 3'b100
  } div_state_t;

endpackage : unbal_pkg

// *** seq_calc.sv ***
`timescale 1ns/1ns
`include "unbal_consts.svh"
module seq_calc (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               in_vld,
  input  wire unbal_pkg::abc_t    abc,
  input  wire logic               phase_rev,
  output logic                    out_vld,
  output logic [`MAG_W-1:0]       pos_sq,
  output logic [`MAG_W-1:0]       neg_sq
);
  localparam int SW = `CUR_W + 3;

  // Rotate by a (sq=0) or a squared (sq=1)
  function automatic logic [2*SW-1:0] rot(input unbal_pkg::phasor_t p,
                                          input logic sq);
    logic signed [29:0]   cx;
    logic signed [29:0]   cy;
    logic signed [SW-1:0] hx;
    logic signed [SW-1:0] hy;
    logic signed [SW-1:0] re;
    logic signed [SW-1:0] im;
    cx = p.re * `ROT_C;
    cy = p.im * `ROT_C;
    hx = SW'(p.re >>> 1);
    hy = SW'(p.im >>> 1);
    re = sq ? -hx + SW'(cy >>> `PU_FRAC) : -hx - SW'(cy >>> `PU_FRAC);
    im = sq ? -SW'(cx >>> `PU_FRAC) - hy : SW'(cx >>> `PU_FRAC) - hy;
    return {re, im};
  endfunction : rot

  function automatic logic [`MAG_W-1:0] magsq(input logic [2*SW-1:0] s);
    logic signed [SW-1:0]   re;
    logic signed [SW-1:0]   im;
    logic signed [2*SW-1:0] re_sq;
    logic signed [2*SW-1:0] im_sq;
    re = s[2*SW-1:SW];
    im = s[SW-1:0];
    re_sq = re * re;
    im_sq = im * im;
    return `MAG_W'(re_sq) + `MAG_W'(im_sq);
  endfunction : magsq

  logic [2*SW-1:0] s_fwd;
  logic [2*SW-1:0] s_bwd;

  // Sums of three times the sequence components
  always_comb begin
    logic [2*SW-1:0] b1;
    logic [2*SW-1:0] c2;
    logic [2*SW-1:0] b2;
    logic [2*SW-1:0] c1;
    b1 = rot(abc.ph_b, 1'b0);
    c2 = rot(abc.ph_c, 1'b1);
    b2 = rot(abc.ph_b, 1'b1);
    c1 = rot(abc.ph_c, 1'b0);
    s_fwd[2*SW-1:SW] = SW'(abc.ph_a.re) + b1[2*SW-1:SW] + c2[2*SW-1:SW];
    s_fwd[SW-1:0]    = SW'(abc.ph_a.im) + b1[SW-1:0] + c2[SW-1:0];
    s_bwd[2*SW-1:SW] = SW'(abc.ph_a.re) + b2[2*SW-1:SW] + c1[2*SW-1:SW];
    s_bwd[SW-1:0]    = SW'(abc.ph_a.im) + b2[SW-1:0] + c1[SW-1:0];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_vld <= 1'b0;
      pos_sq  <= '0;
      neg_sq  <= '0;
    end else begin
      out_vld <= in_vld;
      if (in_vld) begin
        pos_sq <= phase_rev ? magsq(s_bwd) : magsq(s_fwd); // R1 R2
        neg_sq <= phase_rev ? magsq(s_fwd) : magsq(s_bwd); // R1 R2
      end
    end
  end
endmodule : seq_calc

// *** div_serial.sv ***
`timescale 1ns/1ns
module div_serial #(
  parameter int NUM_W = 64,
  parameter int DEN_W = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [DEN_W-1:0] den,
  output logic                  done,
  output logic [NUM_W-1:0]      quot
);
  localparam int CW = $clog2(NUM_W + 1);

  if (NUM_W < DEN_W || DEN_W < 1) begin : g_chk
    $error("div_serial: NUM_W must be at least DEN_W");
  end

  unbal_pkg::div_state_t state_r;
  logic [DEN_W:0]        rem_r;
  logic [DEN_W:0]        rem_sh;
  logic [DEN_W-1:0]      den_r;
  logic [CW-1:0]         cnt_r;
  logic                  fits;

  always_comb begin
    rem_sh = {rem_r[DEN_W-1:0], quot[NUM_W-1]};
    fits   = rem_sh >= {1'b0, den_r};
  end

  // Restoring division, one quotient bit per clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= unbal_pkg::DIV_IDLE;
      rem_r   <= '0;
      den_r   <= '0;
      cnt_r   <= '0;
      quot    <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state_r <= unbal_pkg::DIV_IDLE;
      end else begin
        unique case (state_r)
          unbal_pkg::DIV_IDLE: begin
            if (start) begin
              quot    <= num;
              den_r   <= den;
              rem_r   <= '0;
              cnt_r   <= CW'(NUM_W);
              state_r <= unbal_pkg::DIV_RUN;
            end
          end
          unbal_pkg::DIV_RUN: begin
            rem_r <= fits ? rem_sh - {1'b0, den_r} : rem_sh;
            quot  <= {quot[NUM_W-2:0], fits};
            cnt_r <= cnt_r - CW'(1);
            if (cnt_r == CW'(1)) begin
              done    <= 1'b1;
              state_r <= unbal_pkg::DIV_DONE;
            end
          end
          unbal_pkg::DIV_DONE: begin
            state_r <= unbal_pkg::DIV_IDLE;
          end
          default: begin
            state_r <= unbal_pkg::DIV_IDLE;
          end
        endcase
      end
    end
  end
endmodule : div_serial

// *** unbalance_trip.sv ***
`timescale 1ns/1ns
`include "unbal_consts.svh"
// Contract
// R1: Sequence currents computed from three phases
// R2: Phase order setting swaps positive and negative
// R3: Optional ratio check, negative over positive percent
// R4: Trip only after threshold and ratio hold
// R5: Device base uses device threshold, nominal units
// R6: Object base uses object threshold, object units
// R7: Fixed curve trips after delay setting
// R8: Thermal energy updated at all times
// R9: Inverse curve also needs energy above maximum
// R10: Device base inverse delay, squared difference
// R11: Object base inverse delay, object normalised
// R12: Protection reset clears state and timers
// R13: One parameterised module serves every instance
// R14: Above threshold, energy integrates squared current
// R15: Below threshold, energy decays with time constant
// R16: Below one hundredth of maximum, energy zeroed
// R17: Lapsed pickup restarts delay without tripping
module unbalance_trip #(
  parameter int EVAL_RATE_HZ   = `EVAL_RATE_HZ, // R13
  parameter int DELAY_UNIT_CYC = `DELAY_UNIT_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               smp_vld,
  input  wire unbal_pkg::abc_t    phases,
  input  wire logic               prot_reset,
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  output logic                    trip,
  output logic                    irq
);
  localparam int UW = $clog2(DELAY_UNIT_CYC + 1);

  if (EVAL_RATE_HZ < 1 || DELAY_UNIT_CYC < 1 ||
      `CLK_HZ / EVAL_RATE_HZ < `DIV_CYC_MIN) begin : g_chk
    $error("unbalance_trip: unsupported rate or delay unit");
  end

  // Energy limit product must stay within 64 bits
  if (EVAL_RATE_HZ > `EVAL_RATE_MAX) begin : g_rate_chk
    $error("unbalance_trip: evaluation rate too high");
  end

  // Settings
  unbal_pkg::ctrl_t     ctrl_r;
  logic [15:0]          thr_dev_r;
  logic [15:0]          thr_obj_r;
  logic [7:0]           pct_r;
  logic [15:0]          delay_r;
  logic [15:0]          k_r;
  logic [15:0]          tau_r;
  logic [15:0]          ib_r;
  logic [`EV_W-1:0]     status_r;
  logic [`EV_W-1:0]     mask_r;

  // Element state
  logic                 pickup_r;
  logic                 pick_d_r;
  logic                 trip_d_r;
  logic                 hot_d_r;
  logic [63:0]          theta_r;
  logic                 heating_r;
  logic [UW-1:0]        unit_cnt_r;
  logic [15:0]          dly_cnt_r;

  // Derived values
  logic                 clr;
  logic                 seq_vld;
  logic [`MAG_W-1:0]    pos_sq;
  logic [`MAG_W-1:0]    neg_sq;
  logic [31:0]          thr_prod;
  logic [19:0]          thr_in;
  logic [63:0]          thr_sq9;
  logic                 above;
  logic                 ratio_ok;
  logic                 pickup_now;
  logic [63:0]          base_sq;
  logic [63:0]          theta_max;
  logic [64:0]          theta_sum;
  logic                 theta_over;
  logic [31:0]          tau_ticks;
  logic                 div_start;
  logic                 div_done;
  logic [63:0]          quot;
  logic [63:0]          theta_dec;
  logic                 unit_wrap;
  logic                 trip_nxt;
  logic [`EV_W-1:0]     ev;
  logic [`EV_W-1:0]     status_nxt;

  // Protection reset from pin or command register
  assign clr = prot_reset ||
               (reg_wr && reg_addr == `REG_CMD &&
                reg_wdata[`CMD_PROT_RESET]); // R12

  seq_calc u_seq (
    .mclk      (mclk),
    .rst       (rst),
    .in_vld    (smp_vld),
    .abc       (phases),
    .phase_rev (ctrl_r.phase_rev),
    .out_vld   (seq_vld),
    .pos_sq    (pos_sq),
    .neg_sq    (neg_sq)
  );

  // Threshold in nominal units
  always_comb begin
    thr_prod = thr_obj_r * ib_r;
    if (ctrl_r.obj_base) begin
      thr_in = thr_prod[`PU_FRAC+19:`PU_FRAC]; // R6
    end else begin
      thr_in = 20'(thr_dev_r); // R5
    end
    thr_sq9 = 64'(`SEQ_GAIN_SQ) * 64'(thr_in) * 64'(thr_in);
  end

  // Pickup conditions
  always_comb begin
    above    = 64'(neg_sq) > thr_sq9;
    ratio_ok = !ctrl_r.ratio_en ||
               (64'(`PCT_FULL_SQ) * 64'(neg_sq) >
                64'(pct_r) * 64'(pct_r) * 64'(pos_sq)); // R3
    pickup_now = ctrl_r.enable && above && ratio_ok; // R4
  end

  // Energy limit, scaled to base current squared
  always_comb begin
    base_sq = ctrl_r.obj_base ? 64'(ib_r) * 64'(ib_r) : `PU_ONE_SQ;
    theta_max = 64'(k_r) * 64'(EVAL_RATE_HZ) * 64'(`SEQ_GAIN_SQ) *
                base_sq; // R9 R10 R11
    theta_over = theta_r > theta_max;
  end

  // Heating step and cooling step
  always_comb begin
    theta_sum = {1'b0, theta_r} + {1'b0, 64'(neg_sq) - thr_sq9}; // R14
    tau_ticks = 32'(tau_r) * 32'(EVAL_RATE_HZ);
    theta_dec = theta_r - quot; // R15
    div_start = seq_vld && !above && theta_r != '0 &&
                tau_ticks != '0 && !clr;
  end

  div_serial #(
    .NUM_W (64),
    .DEN_W (32)
  ) u_div (
    .mclk  (mclk),
    .rst   (rst),
    .start (div_start),
    .abort (clr),
    .num   (theta_r),
    .den   (tau_ticks),
    .done  (div_done),
    .quot  (quot)
  );

  // Thermal energy, maintained whatever the curve or pickup
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      theta_r   <= '0;
      heating_r <= 1'b0;
    end else if (clr) begin
      theta_r   <= '0; // R12
      heating_r <= 1'b0;
    end else if (seq_vld) begin
      heating_r <= above; // R8
      if (above) begin
        theta_r <= theta_sum[64] ? '1 : theta_sum[63:0]; // R14
      end else if (tau_ticks == '0) begin
        theta_r <= '0;
      end
    end else if (div_done) begin
      if (theta_dec < theta_max / 64'(`ZERO_FRAC_DIV)) begin
        theta_r <= '0; // R16
      end else begin
        theta_r <= theta_dec; // R15
      end
    end
  end

  // Pickup, refreshed at each evaluation
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pickup_r <= 1'b0;
    end else if (clr) begin
      pickup_r <= 1'b0; // R12
    end else if (seq_vld) begin
      pickup_r <= pickup_now; // R1 R4
    end
  end

  // Delay unit prescaler, runs only while picked up
  assign unit_wrap = unit_cnt_r == UW'(DELAY_UNIT_CYC - 1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      unit_cnt_r <= '0;
    end else if (clr || !pickup_r || unit_wrap) begin
      unit_cnt_r <= '0; // R17
    end else begin
      unit_cnt_r <= unit_cnt_r + UW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dly_cnt_r <= '0;
    end else if (clr || !pickup_r) begin
      dly_cnt_r <= '0; // R12 R17
    end else if (unit_wrap && dly_cnt_r != '1) begin
      dly_cnt_r <= dly_cnt_r + 16'h0001; // R7
    end
  end

  // Trip decision
  always_comb begin
    if (ctrl_r.inverse) begin
      trip_nxt = pickup_r && theta_over; // R9
    end else begin
      trip_nxt = pickup_r && dly_cnt_r >= delay_r; // R7
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trip <= 1'b0;
    end else if (clr) begin
      trip <= 1'b0; // R12
    end else begin
      trip <= trip_nxt; // R4
    end
  end

  // Event edges
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pick_d_r <= 1'b0;
      trip_d_r <= 1'b0;
      hot_d_r  <= 1'b0;
    end else begin
      pick_d_r <= pickup_r;
      trip_d_r <= trip;
      hot_d_r  <= theta_over;
    end
  end

  always_comb begin
    ev = '0;
    ev[`EV_PICKUP] = pickup_r && !pick_d_r;
    ev[`EV_TRIP]   = trip && !trip_d_r;
    ev[`EV_HOT]    = theta_over && !hot_d_r;
    status_nxt = status_r;
    if (reg_wr && reg_addr == `REG_STATUS) begin
      status_nxt = status_r & ~reg_wdata[`EV_W-1:0];
    end
    status_nxt = status_nxt | ev;
  end

  // Sticky status and interrupt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_r <= '0;
      irq      <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |(status_r & mask_r);
    end
  end

  // Register writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r    <= `CTRL_RST;
      thr_dev_r <= `THR_DEV_RST;
      thr_obj_r <= `THR_OBJ_RST;
      pct_r     <= `RATIO_RST;
      delay_r   <= `DELAY_RST;
      k_r       <= `K_RST;
      tau_r     <= `TAU_RST;
      ib_r      <= `IB_RST;
      mask_r    <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `REG_CTRL:    ctrl_r    <= reg_wdata[4:0];
        `REG_THR_DEV: thr_dev_r <= reg_wdata[15:0];
        `REG_THR_OBJ: thr_obj_r <= reg_wdata[15:0];
        `REG_RATIO:   pct_r     <= reg_wdata[7:0];
        `REG_DELAY:   delay_r   <= reg_wdata[15:0];
        `REG_K:       k_r       <= reg_wdata[15:0];
        `REG_TAU:     tau_r     <= reg_wdata[15:0];
        `REG_IB:      ib_r      <= reg_wdata[15:0];
        `REG_MASK:    mask_r    <= reg_wdata[`EV_W-1:0];
        default:      ;
      endcase
    end
  end

  // Register reads, data for one cycle only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL:    reg_rdata <= 32'(ctrl_r);
        `REG_THR_DEV: reg_rdata <= 32'(thr_dev_r);
        `REG_THR_OBJ: reg_rdata <= 32'(thr_obj_r);
        `REG_RATIO:   reg_rdata <= 32'(pct_r);
        `REG_DELAY:   reg_rdata <= 32'(delay_r);
        `REG_K:       reg_rdata <= 32'(k_r);
        `REG_TAU:     reg_rdata <= 32'(tau_r);
        `REG_IB:      reg_rdata <= 32'(ib_r);
        `REG_STATUS:  reg_rdata <= 32'(status_r);
        `REG_MASK:    reg_rdata <= 32'(mask_r);
        `REG_STATE:   reg_rdata <= 32'({theta_r == '0, heating_r,
                                         trip, pickup_r});
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : unbalance_trip

// *** unbalance_trip_props.sv ***
`timescale 1ns/1ns
`include "unbal_consts.svh"
module unbalance_trip_props #(
  parameter int EVAL_RATE_HZ   = `EVAL_RATE_HZ,
  parameter int DELAY_UNIT_CYC = `DELAY_UNIT_CYC
) (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               smp_vld,
  input wire unbal_pkg::abc_t    phases,
  input wire logic               prot_reset,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic               trip,
  input wire logic               irq
);
  logic [2:0] mask_r;
  logic       en_r;

  // Shadow copies of mask and enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_r <= 3'h0;
      en_r <= 1'b0;
    end else if (reg_wr && reg_addr == `REG_MASK) begin
      mask_r <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      en_r <= reg_wdata[0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  rdata_one_shot_a: assert property (
    reg_rdata != 32'h0 |-> $past(reg_rd)) else $error("data without read");
  cmd_reads_zero_a: assert property (
    reg_rd && reg_addr == `REG_CMD |=> reg_rdata == 32'h0)
    else $error("command register read nonzero");
  unmapped_zero_a: assert property (reg_rd && (reg_addr[1:0] != 2'h0 ||
    reg_addr > `REG_CMD) |=> reg_rdata == 32'h0) else $error("unmapped read");
  ratio_width_a: assert property (
    reg_rd && reg_addr == `REG_RATIO |=> reg_rdata[31:8] == 24'h0)
    else $error("ratio upper bits set");
  reset_clears_trip_a: assert property (
    prot_reset |=> !trip) else $error("trip survives protection reset");
  irq_needs_mask_a: assert property (
    irq |-> $past(mask_r) != 3'h0) else $error("irq with mask clear");
  trip_needs_enable_a: assert property (
    $rose(trip) |-> en_r) else $error("trip while disabled");
  quiet_after_reset_a: assert property (
    $fell(rst) |-> !trip && !irq && reg_rdata == 32'h0)
    else $error("outputs active after reset");

  cover property ($rose(trip));
  cover property ($rose(irq));
  cover property (prot_reset && trip);
endmodule : unbalance_trip_props

bind unbalance_trip unbalance_trip_props #(
  .EVAL_RATE_HZ(EVAL_RATE_HZ), .DELAY_UNIT_CYC(DELAY_UNIT_CYC)
) props (
  .mclk(mclk), .rst(rst), .smp_vld(smp_vld), .phases(phases),
  .prot_reset(prot_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trip(trip), .irq(irq)
);

// *** phase_source.sv ***
`timescale 1ns/1ns
module phase_source #(
  parameter int SPACING = 100
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] mag,
  input  wire logic        drop_a,
  input  wire logic        rev,
  output logic             smp_vld,
  output unbal_pkg::abc_t  phases
);
  logic [7:0]  cnt_r;
  logic [15:0] half;
  logic [15:0] sn;
  // Quadrature part of a phase at 120 degrees
  assign half = mag >> 1;
  assign sn = 16'((32'(mag) * 32'h0DDB) >> 12);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      smp_vld <= 1'b0;
      phases <= '0;
    end else begin
      cnt_r <= (cnt_r == 8'(SPACING - 1)) ? 8'h00 : cnt_r + 8'h01;
      smp_vld <= (cnt_r == 8'h00);
      if (cnt_r == 8'h00) begin
        phases.ph_a.re <= drop_a ? 16'h0000 : mag;
        phases.ph_a.im <= 16'h0000;
        phases.ph_b.re <= 16'h0000 - half;
        phases.ph_b.im <= rev ? sn : 16'h0000 - sn;
        phases.ph_c.re <= 16'h0000 - half;
        phases.ph_c.im <= rev ? 16'h0000 - sn : sn;
      end else begin
        // Lines not held between samples
        phases <= ~phases;
      end
    end
  end
endmodule : phase_source

// *** unbalance_trip_test.sv ***
`timescale 1ns/1ns
`include "unbal_consts.svh"
module unbalance_trip_test;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic               prot_reset = 1'b0;
  logic [`ADDR_W-1:0] reg_addr = '0;
  logic [31:0]        reg_wdata = '0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [15:0]        mag = 16'h1000;
  logic               drop_a = 1'b0;
  logic               rev = 1'b0;
  logic               smp_vld;
  logic               trip;
  logic               irq;
  logic [31:0]        reg_rdata;
  logic [31:0]        d;
  logic [15:0]        cs;
  unbal_pkg::abc_t    phases;
  int                 err_total = 0;
  int                 samples_checked = 0;
  int                 cyc = 0;
  localparam logic [31:0] RST_V [10] = '{32'h0, 32'h400, 32'h400, 32'h0,
    32'h3E8, 32'hA, 32'h64, 32'h1000, 32'h0, 32'h0};
  // Case: ctrl[15:11] ratio[10:3] drop[2] reversed[1] pickup[0]
  localparam logic [15:0] CASES [8] = '{16'h0805, 16'h2804, 16'h0800,
    16'h0803, 16'h8802, 16'h49E4, 16'h4945, 16'h0004};

  always #5 mclk = ~mclk;

  unbalance_trip #(.EVAL_RATE_HZ(1), .DELAY_UNIT_CYC(10)) dut (
    .mclk(mclk), .rst(rst), .smp_vld(smp_vld), .phases(phases),
    .prot_reset(prot_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trip(trip), .irq(irq));
  phase_source src (
    .mclk(mclk), .rst(rst), .mag(mag), .drop_a(drop_a), .rev(rev),
    .smp_vld(smp_vld), .phases(phases));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic bchk(input string n, input logic s, input logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask : bchk

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic pulse();
    @(posedge mclk);
    prot_reset <= 1'b1;
    @(posedge mclk);
    prot_reset <= 1'b0;
    #1;
  endtask : pulse

  // Wait for the next sample, then k cycles
  task automatic smp(input int k);
    do begin
      @(posedge mclk);
      #1;
    end while (smp_vld !== 1'b1);
    repeat (k) @(posedge mclk);
    #1;
  endtask : smp

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(6'(4 * i), d);
      chk("reset value", d, RST_V[i]);
    end
    rd(`REG_CMD, d);
    chk("command read", d, 32'h0);
    rd(6'h30, d);
    chk("unmapped read", d, 32'h0);
    wr(`REG_RATIO, 32'hFFFF_FF32);
    rd(`REG_RATIO, d);
    chk("ratio width", d, 32'h32);
    wr(`REG_IB, 32'h2000);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      cs = CASES[i];
      wr(`REG_CTRL, {27'h0, cs[15:11]});
      wr(`REG_RATIO, {24'h0, cs[10:3]});
      drop_a <= cs[2];
      rev <= cs[1];
      smp(4);
      rd(`REG_STATE, d);
      bchk("pickup", d[0], cs[0]);
    end
    $display("test pickup done");
    mag <= 16'h2000;
    drop_a <= 1'b1;
    rev <= 1'b0;
    wr(`REG_K, 32'h1);
    wr(`REG_DELAY, 32'h3);
    wr(`REG_CTRL, 32'h1);
    pulse();
    smp(20);
    bchk("trip", trip, 1'b0);
    repeat (30) @(posedge mclk);
    #1 bchk("trip", trip, 1'b1);
    pulse();
    bchk("trip", trip, 1'b0);
    wr(`REG_DELAY, 32'hF);
    smp(5);
    drop_a <= 1'b0;
    smp(5);
    drop_a <= 1'b1;
    smp(140);
    bchk("trip", trip, 1'b0);
    repeat (30) @(posedge mclk);
    #1 bchk("trip", trip, 1'b1);
    $display("test fixed delay done");
    drop_a <= 1'b0;
    smp(5);
    bchk("trip", trip, 1'b0);
    wr(`REG_CTRL, 32'h3);
    drop_a <= 1'b1;
    smp(5);
    bchk("trip", trip, 1'b1);
    pulse();
    wr(`REG_STATUS, 32'h7);
    for (int i = 1; i <= 3; i++) begin
      smp(5);
      bchk("trip", trip, i == 3);
    end
    rd(`REG_STATUS, d);
    chk("status", d, 32'h7);
    drop_a <= 1'b0;
    smp(5);
    drop_a <= 1'b1;
    smp(5);
    bchk("trip", trip, 1'b1);
    drop_a <= 1'b0;
    wr(`REG_TAU, 32'h1);
    smp(5);
    drop_a <= 1'b1;
    smp(5);
    bchk("trip", trip, 1'b0);
    wr(`REG_CTRL, 32'h7);
    pulse();
    repeat (19) smp(0);
    smp(5);
    bchk("trip", trip, 1'b0);
    smp(5);
    bchk("trip", trip, 1'b1);
    $display("test inverse done");
    drop_a <= 1'b0;
    wr(`REG_DELAY, 32'hFFFF);
    wr(`REG_CTRL, 32'h1);
    pulse();
    wr(`REG_STATUS, 32'h7);
    wr(`REG_MASK, 32'h1);
    #1 bchk("irq", irq, 1'b0);
    drop_a <= 1'b1;
    smp(6);
    bchk("irq", irq, 1'b1);
    rd(`REG_STATUS, d);
    chk("status", d, 32'h1);
    wr(`REG_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    #1 bchk("irq", irq, 1'b0);
    wr(`REG_STATUS, 32'h1);
    rd(`REG_STATUS, d);
    chk("status", d, 32'h0);
    wr(`REG_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    #1 bchk("irq", irq, 1'b0);
    $display("test interrupt done");
    close_out();
  end
endmodule : unbalance_trip_test
